// >>> verilog/lubsig_pkg.sv
// Shared constants, types and command decoder for the lubricator status link.
// Assumes a single 100 MHz clock; all timing runs on a 10 ms tick enable.
package lubsig_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYCLES   = TICK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int LEN_W         = 13;
  localparam int DIV_W         = 32;
  localparam int RUNS_W        = 6;

  // ----------------------------------------------------------------
  // Times in milliseconds, and their tick counts
  // ----------------------------------------------------------------
  localparam int CMD_TOL_MS     = 100;
  localparam int CMD2_MS        = 2000;
  localparam int CMD5_MS        = 5000;
  localparam int CMD8_MS        = 8000;
  localparam int CMD12_MS       = 12000;
  localparam int CMD14_MS       = 14000;
  localparam int GAP_MS         = 3000;
  localparam int PAUSE_MS       = 2000;
  localparam int PREWARN_MS     = 17000;
  localparam int PREWARN_TOL_MS = 100;
  localparam int SQ_HALF_MS     = 1000;
  localparam int SQ_TOL_MS      = 100;
  localparam int ERROR_MS       = 30000;

  // More than 3 s: one tick beyond the figure
  localparam logic [LEN_W-1:0] GAP_T      = LEN_W'(GAP_MS / TICK_MS + 1);
  localparam logic [LEN_W-1:0] PAUSE_T    = LEN_W'(PAUSE_MS / TICK_MS);
  localparam logic [LEN_W-1:0] PREWARN_T  = LEN_W'(PREWARN_MS / TICK_MS);
  localparam logic [LEN_W-1:0] PW_MIN_T   = LEN_W'((PREWARN_MS - PREWARN_TOL_MS) / TICK_MS);
  localparam logic [LEN_W-1:0] PW_MAX_T   = LEN_W'((PREWARN_MS + PREWARN_TOL_MS) / TICK_MS);
  localparam logic [LEN_W-1:0] SQ_HALF_T  = LEN_W'(SQ_HALF_MS / TICK_MS);
  localparam logic [LEN_W-1:0] SQ_MIN_T   = LEN_W'((SQ_HALF_MS - SQ_TOL_MS) / TICK_MS);
  localparam logic [LEN_W-1:0] SQ_MAX_T   = LEN_W'((SQ_HALF_MS + SQ_TOL_MS) / TICK_MS);
  localparam logic [LEN_W-1:0] ERROR_T    = LEN_W'(ERROR_MS / TICK_MS + 1);

  // ----------------------------------------------------------------
  // Stroke counts
  // ----------------------------------------------------------------
  localparam logic [RUNS_W-1:0] RUNS_SINGLE = 6'h01;
  localparam logic [RUNS_W-1:0] RUNS_DOUBLE = 6'h02;
  localparam logic [RUNS_W-1:0] RUNS_FILL   = 6'h28;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {CMD_NONE, CMD_2S, CMD_5S, CMD_8S, CMD_12S, CMD_14S} lubsig_cmd_e;

  function automatic logic lubsig_in_win(input logic [LEN_W-1:0] len, input int ms);
    int l;
    l = int'(len);
    return (l >= (ms - CMD_TOL_MS) / TICK_MS) && (l <= (ms + CMD_TOL_MS) / TICK_MS);
  endfunction

  // Widths outside every window decode to no command
  function automatic lubsig_cmd_e lubsig_decode(input logic [LEN_W-1:0] len);
    lubsig_cmd_e c;
    c = CMD_NONE;
    if (lubsig_in_win(len, CMD2_MS))  c = CMD_2S;
    if (lubsig_in_win(len, CMD5_MS))  c = CMD_5S;
    if (lubsig_in_win(len, CMD8_MS))  c = CMD_8S;
    if (lubsig_in_win(len, CMD12_MS)) c = CMD_12S;
    if (lubsig_in_win(len, CMD14_MS)) c = CMD_14S;
    return c;
  endfunction

  function automatic logic [LEN_W-1:0] lubsig_cmd_ticks(input lubsig_cmd_e c);
    logic [LEN_W-1:0] t;
    t = '0;
    unique case (c)
      CMD_2S:  t = LEN_W'(CMD2_MS / TICK_MS);
      CMD_5S:  t = LEN_W'(CMD5_MS / TICK_MS);
      CMD_8S:  t = LEN_W'(CMD8_MS / TICK_MS);
      CMD_12S: t = LEN_W'(CMD12_MS / TICK_MS);
      CMD_14S: t = LEN_W'(CMD14_MS / TICK_MS);
      default: t = '0;
    endcase
    return t;
  endfunction

endpackage

// >>> verilog/lubsig_if.sv
// Two-wire link: command line toward the lubricator, status line back.
// Both lines are push-pull levels; the bench joins the two ends here.
`timescale 1ns/1ps
interface lubsig_if;
  logic cmdLine;
  logic statusLine;

  modport dev
  (
    input  cmdLine,
    output statusLine
  );
  modport host
  (
    input  statusLine,
    output cmdLine
  );
endinterface

// >>> verilog/lubsig_pulse_meter.sv
// Pin synchroniser and phase-length meter, counted in 10 ms ticks.
// Assumes tick is a one-cycle enable from the owning end's divider.
`timescale 1ns/1ps
module lubsig_pulse_meter
  import lubsig_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  // Pin
  input  wire logic             rawIn,
  // Measurement
  output logic                  level,
  output logic [LEN_W-1:0]      runLen,
  output logic [LEN_W-1:0]      lastLen,
  output logic                  change
);

  typedef struct packed {
    logic [2:0]       sync;
    logic             level;
    logic [LEN_W-1:0] runLen;
    logic [LEN_W-1:0] lastLen;
    logic             change;
  } lubsig_meter_s;

  lubsig_meter_s st_r;
  lubsig_meter_s st_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.sync   = {st_r.sync[1:0], rawIn};
    st_nxt.change = 1'b0;
    // Second and third stage must agree, so a one-cycle glitch never counts
    if (st_r.sync[1] == st_r.sync[2] && st_r.sync[2] != st_r.level)
    begin
      st_nxt.level   = st_r.sync[2];
      st_nxt.lastLen = st_r.runLen;
      st_nxt.runLen  = '0;
      st_nxt.change  = 1'b1;
    end
    else if (tick && st_r.runLen != {LEN_W{1'b1}})
    begin
      st_nxt.runLen = st_r.runLen + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign level   = st_r.level;
  assign runLen  = st_r.runLen;
  assign lastLen = st_r.lastLen;
  assign change  = st_r.change;

endmodule

// >>> verilog/lubsig_device.sv
// Lubricator end: decodes command pulse widths, sequences motor runs and
// encodes the status line. Sensors and motor sit on the same clock.
`timescale 1ns/1ps
module lubsig_device
  import lubsig_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Link
  lubsig_if.dev     link,
  // Sensors
  input  wire logic fillLow,
  input  wire logic emptyDet,
  input  wire logic cartRemoved,
  input  wire logic overPressure,
  input  wire logic supplyBad,
  input  wire logic criticalFault,
  input  wire logic selfCheckOk,
  // Motor
  output logic      motorRun,
  input  wire logic motorDone,
  // Status to local logic
  output logic      errorActive,
  output logic      emptyActive,
  output logic      prewarnActive
);

  typedef enum logic [2:0] {S_READY, S_RUN, S_PAUSE, S_GAP, S_EMPTY, S_ERROR} lubsig_dstate_e;

  typedef struct packed {
    lubsig_dstate_e    state;
    logic [DIV_W-1:0]  divCnt;
    logic              tick;
    logic [LEN_W-1:0]  timer;
    logic [LEN_W-1:0]  pwTimer;
    logic              pwMode;
    logic              runDone;
    logic [RUNS_W-1:0] runsLeft;
    logic              stale;
    logic              errOver;
    logic              errSupply;
    logic              errCrit;
    logic              sqPhase;
    logic              statusOut;
    logic              motorRun;
    logic              errAct;
    logic              emptyAct;
  } lubsig_dev_s;

  lubsig_dev_s st_r;
  lubsig_dev_s st_nxt;

  logic             cmdLevel;
  logic [LEN_W-1:0] cmdRunLen;
  logic [LEN_W-1:0] cmdLastLen;
  logic             cmdChange;
  logic             highEnd;
  lubsig_cmd_e      cmd;

  // ----------------------------------------------------------------
  // Command line measurement
  // ----------------------------------------------------------------
  lubsig_pulse_meter u_meter
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (st_r.tick),
    .rawIn   (link.cmdLine),
    .level   (cmdLevel),
    .runLen  (cmdRunLen),
    .lastLen (cmdLastLen),
    .change  (cmdChange)
  );

  // A high phase just ended: the falling edge of a command
  assign highEnd = cmdChange && !cmdLevel;
  assign cmd     = highEnd ? lubsig_decode(cmdLastLen) : CMD_NONE;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;

    // Time base
    if (st_r.divCnt == DIV_W'(TICK_DIV - 1))
    begin
      st_nxt.divCnt = '0;
      st_nxt.tick   = 1'b1;
    end
    else
    begin
      st_nxt.divCnt = st_r.divCnt + 1'b1;
    end

    // Pulses that began outside ready and error must not decode later in ready
    if (cmdLevel && st_r.state != S_READY && st_r.state != S_ERROR)
      st_nxt.stale = 1'b1;
    else if (highEnd)
      st_nxt.stale = 1'b0;

    unique case (st_r.state)
      S_READY:
      begin
        if (highEnd && !st_r.stale && cmd != CMD_NONE && cmd != CMD_14S)
        begin
          // Motor starts right at the falling edge
          st_nxt.state   = S_RUN;
          st_nxt.runDone = 1'b0;
          st_nxt.pwMode  = fillLow;
          st_nxt.pwTimer = PREWARN_T;
          unique case (cmd)
            CMD_8S:  st_nxt.runsLeft = RUNS_DOUBLE;
            CMD_12S: st_nxt.runsLeft = RUNS_FILL;
            default: st_nxt.runsLeft = RUNS_SINGLE;
          endcase
        end
      end

      S_RUN:
      begin
        if (motorDone)
          st_nxt.runDone = 1'b1;
        if (st_r.tick && st_r.pwTimer != '0)
          st_nxt.pwTimer = st_r.pwTimer - 1'b1;
        if (overPressure)
        begin
          st_nxt.errOver = 1'b1;
          st_nxt.state   = S_ERROR;
        end
        // Low-fill confirmation lasts at least 17 s, longer if the motor is still running
        else if (st_r.runDone && (!st_r.pwMode || st_r.pwTimer == '0))
        begin
          st_nxt.runsLeft = st_r.runsLeft - 1'b1;
          if (emptyDet)
            st_nxt.state = S_EMPTY;
          else if (st_r.runsLeft > RUNS_SINGLE)
          begin
            st_nxt.state = S_PAUSE;
            st_nxt.timer = PAUSE_T;
          end
          else
          begin
            st_nxt.state = S_GAP;
            st_nxt.timer = GAP_T;
          end
          if (emptyDet)
            st_nxt.timer = '0;
          st_nxt.sqPhase = 1'b0;
        end
      end

      S_PAUSE:
      begin
        if (st_r.tick && st_r.timer != '0)
          st_nxt.timer = st_r.timer - 1'b1;
        if (overPressure)
        begin
          st_nxt.errOver = 1'b1;
          st_nxt.state   = S_ERROR;
        end
        else if (highEnd && lubsig_decode(cmdLastLen) == CMD_14S)
        begin
          // Abort: no further stroke
          st_nxt.state    = S_GAP;
          st_nxt.timer    = GAP_T;
          st_nxt.runsLeft = '0;
        end
        // A pending pulse holds the next stroke until it is judged
        else if (st_r.timer == '0 && !cmdLevel)
        begin
          st_nxt.state   = S_RUN;
          st_nxt.runDone = 1'b0;
          st_nxt.pwMode  = fillLow;
          st_nxt.pwTimer = PREWARN_T;
        end
      end

      S_GAP:
      begin
        if (st_r.tick && st_r.timer != '0)
          st_nxt.timer = st_r.timer - 1'b1;
        if (overPressure)
        begin
          st_nxt.errOver = 1'b1;
          st_nxt.state   = S_ERROR;
        end
        else if (st_r.timer == '0)
          st_nxt.state = S_READY;
      end

      S_EMPTY:
      begin
        // Delivery stays off; acknowledge has no effect here
        if (st_r.tick)
          st_nxt.timer = st_r.timer + 1'b1;
        if (st_r.tick && st_r.timer == SQ_HALF_T - 1'b1)
        begin
          st_nxt.timer   = '0;
          st_nxt.sqPhase = !st_r.sqPhase;
        end
        if (cartRemoved)
          st_nxt.state = S_READY;
      end

      S_ERROR:
      begin
        if (cmd == CMD_14S)
        begin
          if (!st_r.errCrit && selfCheckOk)
          begin
            st_nxt.errOver   = 1'b0;
            st_nxt.errSupply = 1'b0;
            st_nxt.state     = S_READY;
          end
        end
        // Failing check leaves the error latched
      end
    endcase

    // Asynchronous faults override any sequence
    if (supplyBad)
    begin
      st_nxt.errSupply = 1'b1;
      st_nxt.state     = S_ERROR;
    end
    if (criticalFault || st_r.errCrit)
    begin
      st_nxt.errCrit = 1'b1;
      st_nxt.state   = S_ERROR;
    end

    // Status encoding follows the next state
    unique case (st_nxt.state)
      S_READY: st_nxt.statusOut = 1'b1;
      S_PAUSE: st_nxt.statusOut = 1'b1;
      S_GAP:   st_nxt.statusOut = 1'b1;
      S_RUN:   st_nxt.statusOut = 1'b0;
      S_EMPTY: st_nxt.statusOut = st_nxt.sqPhase;
      S_ERROR: st_nxt.statusOut = 1'b0;
    endcase
    st_nxt.motorRun = (st_nxt.state == S_RUN) && !st_nxt.runDone;
    st_nxt.errAct   = st_nxt.state == S_ERROR;
    st_nxt.emptyAct = st_nxt.state == S_EMPTY;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r           <= '0;
      st_r.state     <= S_GAP;
      st_r.timer     <= GAP_T;
      st_r.statusOut <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.statusLine = st_r.statusOut;
  assign motorRun        = st_r.motorRun;
  assign errorActive     = st_r.errAct;
  assign emptyActive     = st_r.emptyAct;
  assign prewarnActive   = st_r.pwMode;

endmodule

// >>> verilog/lubsig_host.sv
// Controller end: sends timed command pulses and interprets the status line.
// Assumes the lubricator end drives statusLine; sampled via the meter's sync.
`timescale 1ns/1ps
module lubsig_host
  import lubsig_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Link
  lubsig_if.host            link,
  // Command request
  input  wire logic         cmdReq,
  input  wire lubsig_cmd_e  cmdCode,
  output logic              cmdBusy,
  output logic              cmdRefused,
  output logic              cmdDone,
  // Interpreted status
  output logic              devReady,
  output logic              devError,
  output logic              devPrewarn,
  output logic              devEmpty
);

  typedef struct packed {
    logic [DIV_W-1:0] divCnt;
    logic             tick;
    logic             busy;
    logic [LEN_W-1:0] timer;
    logic             cmdLine;
    logic             refused;
    logic             done;
    logic [1:0]       pwCount;
    logic             ready;
    logic             error;
    logic             prewarn;
    logic             empty;
  } lubsig_host_s;

  lubsig_host_s st_r;
  lubsig_host_s st_nxt;

  logic             stLevel;
  logic [LEN_W-1:0] stRunLen;
  logic [LEN_W-1:0] stLastLen;
  logic             stChange;
  logic             okAck;
  logic             okCmd;

  lubsig_pulse_meter u_meter
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (st_r.tick),
    .rawIn   (link.statusLine),
    .level   (stLevel),
    .runLen  (stRunLen),
    .lastLen (stLastLen),
    .change  (stChange)
  );

  // Acknowledge needs low over 3 s, others high over 3 s
  assign okAck = !stLevel && stRunLen >= GAP_T;
  assign okCmd = stLevel && stRunLen >= GAP_T;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.tick    = 1'b0;
    st_nxt.refused = 1'b0;
    st_nxt.done    = 1'b0;
    if (st_r.divCnt == DIV_W'(TICK_DIV - 1))
    begin
      st_nxt.divCnt = '0;
      st_nxt.tick   = 1'b1;
    end
    else
    begin
      st_nxt.divCnt = st_r.divCnt + 1'b1;
    end

    // Pulse generation
    if (!st_r.busy)
    begin
      if (cmdReq)
      begin
        if (cmdCode != CMD_NONE && ((cmdCode == CMD_14S) ? okAck : okCmd))
        begin
          st_nxt.busy    = 1'b1;
          st_nxt.cmdLine = 1'b1;
          st_nxt.timer   = lubsig_cmd_ticks(cmdCode);
        end
        else
          st_nxt.refused = 1'b1;
      end
    end
    else if (st_r.tick)
    begin
      st_nxt.timer = st_r.timer - 1'b1;
      if (st_r.timer == LEN_W'(1))
      begin
        st_nxt.busy    = 1'b0;
        st_nxt.cmdLine = 1'b0;
        st_nxt.done    = 1'b1;
      end
    end

    // Low phase classification on each rising edge of status
    if (stChange && stLevel)
    begin
      if (stLastLen >= PW_MIN_T && stLastLen <= PW_MAX_T)
      begin
        if (st_r.pwCount != 2'h3)
          st_nxt.pwCount = st_r.pwCount + 1'b1;
      end
      else if (stLastLen >= SQ_MIN_T && stLastLen <= SQ_MAX_T)
        st_nxt.empty = 1'b1;
      else
        st_nxt.pwCount = 2'h0;
    end
    st_nxt.prewarn = st_nxt.pwCount == 2'h3;
    // Long steady high ends the square wave reading
    if (okCmd)
      st_nxt.empty = 1'b0;
    st_nxt.ready = okCmd && !st_nxt.empty;
    st_nxt.error = !stLevel && stRunLen >= ERROR_T;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.cmdLine = st_r.cmdLine;
  assign cmdBusy      = st_r.busy;
  assign cmdRefused   = st_r.refused;
  assign cmdDone      = st_r.done;
  assign devReady     = st_r.ready;
  assign devError     = st_r.error;
  assign devPrewarn   = st_r.prewarn;
  assign devEmpty     = st_r.empty;

endmodule

// >>> verification/lubsig_link_monitor.sv
// Checker watching the two link wires between both ends.
// Assumes the bench clock and reset, and the tick divider of both ends.
`timescale 1ns/1ps
module lubsig_link_monitor
  import lubsig_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Link
  input  wire logic cmdLine,
  input  wire logic statusLine
);
  // ----
  // Phase counters
  // ----
  logic [31:0] statCnt_r;
  logic [31:0] hiCnt_r;
  logic        statPrev_r;

  always_ff @(posedge clk)
  begin
    statPrev_r <= statusLine;
    statCnt_r  <= (!rst_n || statusLine != statPrev_r) ? 32'h0 : statCnt_r + 32'h1;
    hiCnt_r    <= (!rst_n || !cmdLine) ? 32'h0 : hiCnt_r + 32'h1;
  end

  // Tick phase makes a pulse up to one tick short
  function automatic logic widthOk(input logic [31:0] n);
    int t[5] = '{200, 500, 800, 1200, 1400};
    widthOk = 1'b0;
    foreach (t[i])
      if (n >= (t[i] - 1) * TICK_DIV - 1 && n <= t[i] * TICK_DIV + 1)
        widthOk = 1'b1;
  endfunction

  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence shortCmdEnd;
    $fell(cmdLine) && statusLine && hiCnt_r < 32'(1300 * TICK_DIV);
  endsequence
  sequence confirmLow;
    ##[1:16] !statusLine;
  endsequence

  AST_STATUS_RST: assert property ($rose(rst_n) |-> statusLine)
    else $error("status low at reset release");
  AST_CMD_RST: assert property ($rose(rst_n) |-> !cmdLine)
    else $error("command line high at reset release");
  AST_CMD_WIDTH: assert property ($fell(cmdLine) |-> widthOk(hiCnt_r))
    else $error("command pulse width outside windows");
  AST_CMD_AFTER_STEADY: assert property ($rose(cmdLine) |-> statCnt_r > 32'(300 * TICK_DIV))
    else $error("command started before status was steady");
  AST_CONFIRM: assert property (shortCmdEnd |-> confirmLow)
    else $error("no low confirmation after command");
  AST_ACK_HOLDS_LOW: assert property (cmdLine && !statusLine |=> !statusLine)
    else $error("status rose during command pulse");
  AST_RX_HOLDS_HIGH: assert property (cmdLine && statusLine |=> statusLine)
    else $error("status fell during command pulse");
  AST_CMD_QUIET: assert property ($fell(cmdLine) |=> !cmdLine [*8])
    else $error("command line rose right after a pulse");
endmodule

// >>> verification/lubricator_status_ack_signalling_tb_top.sv
// Bench joining controller end and lubricator end over the link.
// Assumes a shortened tick divider; sensors and motor are driven here.
`timescale 1ns/1ps
module lubricator_status_ack_signalling_tb_top
  import lubsig_pkg::*;
;
  // ----
  // Signals
  // ----
  localparam int D = 2;
  localparam int RDY = 0;
  localparam int STS = 1;
  localparam int MOT = 2;
  localparam int ERR = 3;
  localparam int PRW = 4;
  logic        clk;
  logic        rst_n;
  logic        fillLow, emptyDet, cartRemoved, overPressure, supplyBad, criticalFault, selfCheckOk;
  logic        motorRun, motorDone, errorActive, emptyActive, prewarnActive;
  logic        cmdReq, cmdBusy, cmdRefused, cmdDone, devReady, devError, devPrewarn, devEmpty;
  lubsig_cmd_e cmdCode;
  int          failures;
  int          checked;
  logic        busySeen;

  lubsig_if i_lubsig_if ();
  lubsig_device #(.TICK_DIV(D)) i_lubsig_device (.clk(clk), .rst_n(rst_n), .link(i_lubsig_if.dev),
    .fillLow(fillLow), .emptyDet(emptyDet), .cartRemoved(cartRemoved), .overPressure(overPressure),
    .supplyBad(supplyBad), .criticalFault(criticalFault), .selfCheckOk(selfCheckOk), .motorRun(motorRun),
    .motorDone(motorDone), .errorActive(errorActive), .emptyActive(emptyActive), .prewarnActive(prewarnActive));
  lubsig_host #(.TICK_DIV(D)) i_lubsig_host (.clk(clk), .rst_n(rst_n), .link(i_lubsig_if.host),
    .cmdReq(cmdReq), .cmdCode(cmdCode), .cmdBusy(cmdBusy), .cmdRefused(cmdRefused), .cmdDone(cmdDone),
    .devReady(devReady), .devError(devError), .devPrewarn(devPrewarn), .devEmpty(devEmpty));
  lubsig_link_monitor #(.TICK_DIV(D)) i_lubsig_link_monitor (.clk(clk), .rst_n(rst_n),
    .cmdLine(i_lubsig_if.cmdLine), .statusLine(i_lubsig_if.statusLine));

  // ----
  // Tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait; the caller compares afterwards
  task automatic waitFor(input int sel, input logic v, input int lim);
    int   n;
    logic s;
    n = 0;
    s = ~v;
    while (s !== v && n < lim)
    begin
      @(negedge clk);
      n++;
      case (sel)
        RDY:     s = devReady;
        STS:     s = i_lubsig_if.statusLine;
        MOT:     s = motorRun;
        ERR:     s = devError;
        default: s = devPrewarn;
      endcase
    end
  endtask

  // Result: 01 pulse sent, 10 refused
  task automatic send(input lubsig_cmd_e c, output logic [1:0] res);
    int n;
    res = 2'b00;
    n = 0;
    @(posedge clk);
    cmdReq  <= 1'b1;
    cmdCode <= c;
    @(posedge clk);
    cmdReq <= 1'b0;
    while (res == 2'b00 && n < 1500 * D)
    begin
      @(negedge clk);
      n++;
      res = {cmdRefused, cmdDone};
      if (n == 1)
        busySeen = cmdBusy;
    end
  endtask

  task automatic runEnd();
    @(posedge clk) motorDone <= 1'b1;
    @(posedge clk) motorDone <= 1'b0;
  endtask

  task automatic print_verdict();
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----
  // Stimulus
  // ----
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial
  begin
    logic [1:0] r;
    {rst_n, fillLow, emptyDet, cartRemoved, overPressure, supplyBad, criticalFault} = 7'h00;
    {selfCheckOk, motorDone, cmdReq, failures, checked} = '0;
    cmdCode = CMD_NONE;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    waitFor(RDY, 1'b1, 400 * D);
    check(devReady, 1'b1);
    send(CMD_2S, r);
    check(r, 2'b01);
    check(busySeen, 1'b1);
    waitFor(MOT, 1'b1, 20);
    check(i_lubsig_if.statusLine, 1'b0);
    runEnd();
    waitFor(STS, 1'b1, 20);
    send(CMD_5S, r);
    check(r, 2'b10);
    check(busySeen, 1'b0);
    // Repeated fill: forty strokes with 2 s high pauses
    waitFor(RDY, 1'b1, 400 * D);
    send(CMD_12S, r);
    for (int i = 0; i < 40; i++)
    begin
      waitFor(MOT, 1'b1, 250 * D);
      check(motorRun, 1'b1);
      runEnd();
      waitFor(STS, 1'b1, 20);
      tick(190 * D);
      check({i_lubsig_if.statusLine, motorRun}, 2'b10);
    end
    waitFor(MOT, 1'b1, 250 * D);
    check(motorRun, 1'b0);
    // Low fill: six 17 s lows from three double-stroke commands, each run ending early
    @(posedge clk) fillLow <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      waitFor(RDY, 1'b1, 400 * D);
      send(CMD_8S, r);
      // Two strokes, the second after the 2 s pause
      for (int k = 0; k < 2; k++)
      begin
        waitFor(MOT, 1'b1, 250 * D);
        runEnd();
        tick(1680 * D);
        check(i_lubsig_if.statusLine, 1'b0);
        waitFor(STS, 1'b1, 40 * D);
        check(i_lubsig_if.statusLine, 1'b1);
      end
      if (i == 0)
        check(devPrewarn, 1'b0);
    end
    waitFor(PRW, 1'b1, 20);
    check({devPrewarn, prewarnActive}, 2'b11);
    @(posedge clk) fillLow <= 1'b0;
    // Empty cartridge after a dispense
    @(posedge clk) emptyDet <= 1'b1;
    waitFor(RDY, 1'b1, 400 * D);
    send(CMD_2S, r);
    waitFor(MOT, 1'b1, 20);
    runEnd();
    waitFor(STS, 1'b1, 400 * D);
    waitFor(STS, 1'b0, 120 * D);
    tick(95 * D);
    check(i_lubsig_if.statusLine, 1'b0);
    waitFor(STS, 1'b1, 10 * D);
    check(i_lubsig_if.statusLine, 1'b1);
    check({devEmpty, emptyActive}, 2'b11);
    send(CMD_14S, r);
    check(r, 2'b10);
    @(posedge clk) emptyDet <= 1'b0;
    cartRemoved <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      tick(70 * D);
      check({i_lubsig_if.statusLine, emptyActive}, 2'b10);
    end
    @(posedge clk) cartRemoved <= 1'b0;
    // Supply fault, failing then passing self-check
    waitFor(RDY, 1'b1, 400 * D);
    @(posedge clk) supplyBad <= 1'b1;
    waitFor(STS, 1'b0, 20);
    @(posedge clk) supplyBad <= 1'b0;
    waitFor(ERR, 1'b1, 3100 * D);
    check({devError, errorActive}, 2'b11);
    send(CMD_2S, r);
    check(r, 2'b10);
    send(CMD_14S, r);
    tick(20);
    check(i_lubsig_if.statusLine, 1'b0);
    @(posedge clk) selfCheckOk <= 1'b1;
    send(CMD_14S, r);
    waitFor(STS, 1'b1, 20);
    check(i_lubsig_if.statusLine, 1'b1);
    // Overload during a run
    waitFor(RDY, 1'b1, 400 * D);
    send(CMD_2S, r);
    waitFor(MOT, 1'b1, 20);
    @(posedge clk) overPressure <= 1'b1;
    runEnd();
    @(posedge clk) overPressure <= 1'b0;
    tick(310 * D);
    check({i_lubsig_if.statusLine, errorActive}, 2'b01);
    send(CMD_14S, r);
    waitFor(STS, 1'b1, 20);
    check(i_lubsig_if.statusLine, 1'b1);
    // Critical fault beside a supply fault survives acknowledge
    waitFor(RDY, 1'b1, 400 * D);
    @(posedge clk) criticalFault <= 1'b1;
    supplyBad <= 1'b1;
    @(posedge clk) criticalFault <= 1'b0;
    supplyBad <= 1'b0;
    tick(310 * D);
    send(CMD_14S, r);
    tick(20);
    check({i_lubsig_if.statusLine, errorActive}, 2'b01);
    @(posedge clk) rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    waitFor(RDY, 1'b1, 400 * D);
    check({i_lubsig_if.statusLine, devReady}, 2'b11);
    print_verdict();
  end
endmodule
